// [verification/xmhk_checker.sv]
// Concurrent checks on the external cycle and keeper pins of xmhk_top.
// Assumes one clock domain on hclk, hresetn active low.
`timescale 1ns/1ps
`default_nettype none
module xmhk_checker (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       acc_done,
    input wire logic       acc_ext,
    input wire logic [7:0] ad_out,
    input wire logic [7:0] ad_oe,
    input wire logic [7:0] ad_keep_val,
    input wire logic       ale,
    input wire logic       rd_n,
    input wire logic       wr_n
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ale_pulse_a: assert property (ale |=> !ale)
        else $error("ale held past one cycle");
    strobe_excl_a: assert property (rd_n || wr_n)
        else $error("read and write strobes together");
    ale_strobe_a: assert property (ale |-> ##2 (!rd_n || !wr_n))
        else $error("no strobe two cycles after ale");
    ale_done_a: assert property (ale |-> ##5 (acc_done && acc_ext))
        else $error("external access not done five cycles after ale");
    int_quiet_a: assert property ((acc_done && !acc_ext) |-> (rd_n && wr_n && !$past(ale)))
        else $error("internal access moved the memory pins");
    rd_len_a: assert property ($fell(rd_n) |-> !rd_n [*3] ##1 rd_n)
        else $error("read strobe not three cycles");
    wr_len_a: assert property ($fell(wr_n) |-> (!wr_n && ad_oe == 8'hFF) [*3] ##1 wr_n)
        else $error("write strobe or data drive wrong");
    rd_free_a: assert property ((!rd_n && !$past(rd_n)) |-> ad_oe == 8'h00)
        else $error("bus driven during read");
    keep_hold_a: assert property ((ad_oe == 8'h00) [*3] |-> $stable(ad_keep_val))
        else $error("kept value moved while bus released");
    keep_track_a: assert property ((ad_oe == 8'hFF && $stable(ad_out)) [*2] |-> ad_keep_val == ad_out)
        else $error("kept value differs from driven value");
endmodule // xmhk_checker
bind xmhk_top xmhk_checker chk_i (.hclk(hclk), .hresetn(hresetn), .acc_done(acc_done), .acc_ext(acc_ext),
    .ad_out(ad_out), .ad_oe(ad_oe), .ad_keep_val(ad_keep_val), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
`default_nettype wire

// [verification/xmhk_ext_sram.sv]
// External parallel memory model for the multiplexed bus.
// Assumes pins already resolved by the bench; samples on hclk rising edges.
`timescale 1ns/1ps
`default_nettype none
module xmhk_ext_sram #(
    parameter int RD_LAG = 1
) (
    input  wire logic        hclk,
    input  wire logic        ale,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [7:0]  ad,
    input  wire logic [7:0]  hi,
    output logic             dq_oe,
    output logic [15:0]      addr,
    output logic [7:0]       dq
);
    logic [7:0] mem [0:65535];
    int         lag;
    // Low byte valid only in the ale and hold cycles, so latch it while ale is high
    always @(posedge hclk)
    begin
        if (ale)
            addr <= {hi, ad};
        if (!wr_n)
            mem[addr] <= ad;
        lag <= rd_n ? 0 : lag + 1;
    end
    // Slow device: data appears RD_LAG cycles into the strobe
    assign dq_oe = !rd_n && lag >= RD_LAG;
    assign dq = mem[addr];
endmodule // xmhk_ext_sram
`default_nettype wire

// [verification/xmhk_top_tb.sv]
// Self-checking bench for xmhk_top: AHB-Lite register master, core access port, memory model.
// Assumes the design files and xmhk_consts.svh are on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "xmhk_consts.svh"
module xmhk_top_tb;
    logic        hclk, hresetn, hsel, hwrite, acc_req, acc_write, hreadyout, hresp;
    logic        acc_done, acc_ext, ad_keep_en, ale, rd_n, wr_n, mem_oe;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] acc_addr, mem_addr;
    logic [7:0]  acc_wdata, acc_rdata, ad_w, ad_out, ad_oe, ad_keep_val, hi_w, hi_out, hi_oe, mem_dq;
    logic [7:0]  ad_last = 8'h00;
    logic [7:0]  hi_last = 8'h00;
    int          bad_count, n_compared;
    xmhk_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .acc_req(acc_req), .acc_addr(acc_addr), .acc_write(acc_write),
        .acc_wdata(acc_wdata), .acc_done(acc_done), .acc_ext(acc_ext), .acc_rdata(acc_rdata),
        .ad_in(ad_w), .ad_out(ad_out), .ad_oe(ad_oe), .ad_keep_en(ad_keep_en), .ad_keep_val(ad_keep_val),
        .hi_in(hi_w), .hi_out(hi_out), .hi_oe(hi_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
    // Data must stand from the first strobe cycle: the design samples it through a two-stage sync
    xmhk_ext_sram #(.RD_LAG(0)) mem_i (.hclk(hclk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .ad(ad_w),
        .hi(hi_w), .dq_oe(mem_oe), .addr(mem_addr), .dq(mem_dq));
    // Undriven lines flip each cycle so a stale value can never pass for a kept one
    assign ad_w = (ad_oe & ad_out) | (~ad_oe & (mem_oe ? mem_dq : ad_keep_en ? ad_keep_val : ~ad_last));
    assign hi_w = (hi_oe & hi_out) | (~hi_oe & ~hi_last);
    always @(posedge hclk)
    begin
        ad_last <= ad_w;
        hi_last <= hi_w;
    end
    initial
    begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (bad_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_on(input logic use_done);
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
            if (n > 40)
            begin
                bad_count++;
                $display("unexpected at %0t: wait ran out", $time);
                report_and_stop;
            end
        end
        while ((use_done ? acc_done : hreadyout) !== 1'b1);
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_on(1'b0);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_on(1'b0);
        rv = hrdata;
    endtask
    task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
        acc_req <= 1'b1;
        acc_addr <= a;
        acc_write <= w;
        acc_wdata <= d;
        wait_on(1'b1);
        acc_req <= 1'b0;
        @(posedge hclk);
    endtask
    task automatic t_regs;
        for (int o = 0; o < 24; o += 4)
        begin
            ahb(1'b0, o[7:0], 32'h0);
            chk(rv, 32'h0);
        end
        ahb(1'b1, `XMHK_OFF_SFIOC, 32'h78);
        ahb(1'b1, 8'h1C, 32'hFF);
        ahb(1'b0, `XMHK_OFF_SFIOC, 32'h0);
        chk(rv, 32'h78);
        chk({hresp, hreadyout}, 2'h1);
        ahb(1'b0, 8'h1C, 32'h0);
        chk(rv, 32'h0);
        ahb(1'b1, `XMHK_OFF_SFIOC, 32'h0);
    endtask
    task automatic t_bound;
        logic [15:0] at [4] = '{16'h04FF, 16'h0500, 16'h045F, 16'h0460};
        for (int i = 0; i < 4; i++)
        begin
            ahb(1'b1, `XMHK_OFF_EXTCTL, 32'h80 | (i / 2));
            acc(at[i], 1'b1, 8'h00);
            chk(acc_ext, i[0]);
        end
    endtask
    task automatic t_mask;
        ahb(1'b1, `XMHK_OFF_HI_DIR, 32'hFF);
        ahb(1'b1, `XMHK_OFF_HI_PORT, 32'h00);
        ahb(1'b1, `XMHK_OFF_EXTCTL, 32'h80);
        for (int m = 0; m < 8; m++)
        begin
            ahb(1'b1, `XMHK_OFF_SFIOC, m << 3);
            acc(16'hFF10, 1'b1, m[7:0]);
            chk(mem_addr, {(m == 7) ? 8'h00 : (8'hFF >> m), 8'h10});
        end
        ahb(1'b1, `XMHK_OFF_SFIOC, 32'h18);
        acc(16'h2001, 1'b1, 8'hAA);
        ahb(1'b1, `XMHK_OFF_SFIOC, 32'h00);
        acc(16'h2001, 1'b1, 8'h55);
        chk(mem_i.mem[16'h0001], 8'hAA);
        acc(16'h2001, 1'b0, 8'h00);
        chk(acc_rdata, 8'h55);
        ahb(1'b1, `XMHK_OFF_SFIOC, 32'h38);
        ahb(1'b1, `XMHK_OFF_HI_DIR, 32'h0F);
        ahb(1'b1, `XMHK_OFF_HI_PORT, 32'h5A);
        // Mask is latched per cycle, so one cycle is needed before the release shows
        acc(16'h8000, 1'b1, 8'h00);
        repeat (3) @(posedge hclk);
        chk({hi_oe, hi_out}, 16'h0F5A);
    endtask
    task automatic t_keep;
        ahb(1'b1, `XMHK_OFF_SFIOC, 32'h40);
        acc(16'h3000, 1'b1, 8'hC3);
        repeat (3) @(posedge hclk);
        chk({ad_keep_en, ad_keep_val}, 9'h1C3);
        ahb(1'b1, `XMHK_OFF_EXTCTL, 32'h00);
        repeat (3) @(posedge hclk);
        chk(ad_keep_en, 1'b1);
        ahb(1'b1, `XMHK_OFF_SFIOC, 32'h00);
        repeat (3) @(posedge hclk);
        chk(ad_keep_en, 1'b0);
    endtask
    task automatic t_port;
        ahb(1'b1, `XMHK_OFF_AD_DIR, 32'hFF);
        ahb(1'b1, `XMHK_OFF_AD_PORT, 32'h96);
        acc(16'h8000, 1'b1, 8'h11);
        chk({acc_ext, ad_oe, ad_out}, 17'h0FF96);
        ahb(1'b0, `XMHK_OFF_STATUS, 32'h0);
        chk(rv & 32'h000100FF, 32'h96);
    endtask
    task automatic t_late;
        ahb(1'b1, `XMHK_OFF_EXTCTL, 32'h80);
        ahb(1'b1, `XMHK_OFF_HI_DIR, 32'hFF);
        ahb(1'b1, `XMHK_OFF_HI_PORT, 32'h00);
        // Mask write lands while the first cycle is already under way
        fork
            acc(16'hF0F0, 1'b1, 8'h77);
            begin
                @(posedge hclk);
                ahb(1'b1, `XMHK_OFF_SFIOC, 32'h18);
            end
        join
        chk(mem_addr, 16'hF0F0);
        acc(16'hF0F0, 1'b1, 8'h77);
        chk(mem_addr, 16'h10F0);
    endtask
    initial
    begin
        bad_count = 0;
        n_compared = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        acc_req = 1'b0;
        acc_addr = 16'h0;
        acc_write = 1'b0;
        acc_wdata = 8'h00;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_bound;
        t_mask;
        t_keep;
        t_port;
        t_late;
        report_and_stop;
    end
endmodule // xmhk_top_tb
`default_nettype wire

// [verilog/xmhk_consts.svh]
// Offsets, field positions, reset values and cycle counts of the external memory mask and keeper block.
// Included by bare name; holds definitions only.
`ifndef XMHK_CONSTS_SVH
`define XMHK_CONSTS_SVH

`define XMHK_OFF_SFIOC        8'h00
`define XMHK_OFF_EXTCTL       8'h04
`define XMHK_OFF_AD_PORT      8'h08
`define XMHK_OFF_AD_DIR       8'h0C
`define XMHK_OFF_HI_PORT      8'h10
`define XMHK_OFF_HI_DIR       8'h14
`define XMHK_OFF_STATUS       8'h18

`define XMHK_BIT_KEEPER       6
`define XMHK_MASK_MSB         5
`define XMHK_MASK_LSB         3
`define XMHK_BIT_EXT_EN       7
`define XMHK_BIT_COMPAT       0
`define XMHK_BIT_BUSY         16

`define XMHK_RST_REG8         8'h00
`define XMHK_INT_TOP_NORMAL   16'h04FF
`define XMHK_INT_TOP_COMPAT   16'h045F
`define XMHK_STROBE_CYCLES    2'h3
`define XMHK_HI_BITS          4'h8

`endif

// [verilog/xmhk_cyc_if.sv]
// Carrier between the register side and the external cycle sequencer.
// Assumes both ends run on hclk.
`timescale 1ns/1ps
`default_nettype none
interface xmhk_cyc_if;
    logic        start;
    logic [15:0] addr;
    logic        write;
    logic [7:0]  wdata;
    logic [2:0]  mask;
    logic [7:0]  ad_in;
    logic        busy;
    logic        done;
    logic [7:0]  rdata;
    logic [7:0]  ad_out;
    logic        ad_oe;
    logic [7:0]  hi_addr;
    logic [2:0]  cur_mask;
    logic        ale;
    logic        rd_n;
    logic        wr_n;
    modport ctrl (output start, addr, write, wdata, mask, ad_in,
                  input busy, done, rdata, ad_out, ad_oe, hi_addr, cur_mask, ale, rd_n, wr_n);
    modport seq  (input start, addr, write, wdata, mask, ad_in,
                  output busy, done, rdata, ad_out, ad_oe, hi_addr, cur_mask, ale, rd_n, wr_n);
endinterface
`default_nettype wire

// [verilog/xmhk_cycle.sv]
// External memory cycle sequencer: latch strobe, address hold, read or write strobe.
// Assumes ad_in is already synchronised and start only comes while busy is low.
`timescale 1ns/1ps
`default_nettype none
`include "xmhk_consts.svh"
module xmhk_cycle (
    input  wire logic    hclk,
    input  wire logic    hresetn,
    xmhk_cyc_if.seq      cyc
);
    xmhk_pkg::xmhk_state_t state;
    xmhk_pkg::xmhk_state_t next_state;
    logic [15:0] addr;
    logic [15:0] next_addr;
    logic        write;
    logic        next_write;
    logic [7:0]  wdata;
    logic [7:0]  next_wdata;
    logic [2:0]  mask;
    logic [2:0]  next_mask;
    logic [1:0]  cnt;
    logic [1:0]  next_cnt;
    logic [7:0]  rdata;
    logic [7:0]  next_rdata;

    always_comb
    begin
        next_state = state;
        next_addr  = addr;
        next_write = write;
        next_wdata = wdata;
        next_mask  = mask;
        next_cnt   = cnt;
        next_rdata = rdata;
        case (state)
            xmhk_pkg::XMHK_IDLE:
            begin
                if (cyc.start)
                begin
                    next_addr  = cyc.addr;
                    next_write = cyc.write;
                    next_wdata = cyc.wdata;
                    // Mask is frozen here so a later write cannot bend a cycle already running
                    next_mask  = cyc.mask;
                    next_state = xmhk_pkg::XMHK_ALE;
                end
            end
            xmhk_pkg::XMHK_ALE:
                next_state = xmhk_pkg::XMHK_HOLD;
            xmhk_pkg::XMHK_HOLD:
            begin
                next_cnt   = `XMHK_STROBE_CYCLES;
                next_state = xmhk_pkg::XMHK_STROBE;
            end
            xmhk_pkg::XMHK_STROBE:
            begin
                next_cnt = cnt - 2'h1;
                if (cnt == 2'h1)
                    next_state = xmhk_pkg::XMHK_END;
            end
            xmhk_pkg::XMHK_END:
            begin
                // Pin register and two sync stages trail the strobe by three cycles, so sample here
                next_rdata = cyc.ad_in;
                next_state = xmhk_pkg::XMHK_IDLE;
            end
            default:
                next_state = xmhk_pkg::XMHK_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= xmhk_pkg::XMHK_IDLE;
            addr  <= 16'h0000;
            write <= 1'b0;
            wdata <= 8'h00;
            mask  <= 3'h0;
            cnt   <= 2'h0;
            rdata <= 8'h00;
        end
        else
        begin
            state <= next_state;
            addr  <= next_addr;
            write <= next_write;
            wdata <= next_wdata;
            mask  <= next_mask;
            cnt   <= next_cnt;
            rdata <= next_rdata;
        end
    end

    assign cyc.busy     = (state != xmhk_pkg::XMHK_IDLE);
    assign cyc.done     = (state == xmhk_pkg::XMHK_END);
    assign cyc.rdata    = (state == xmhk_pkg::XMHK_END) ? cyc.ad_in : rdata;
    assign cyc.hi_addr  = addr[15:8];
    assign cyc.cur_mask = mask;
    assign cyc.ale      = (state == xmhk_pkg::XMHK_ALE);
    assign cyc.rd_n     = !((state == xmhk_pkg::XMHK_STROBE) && !write);
    assign cyc.wr_n     = !((state == xmhk_pkg::XMHK_STROBE) && write);
    assign cyc.ad_out   = (state == xmhk_pkg::XMHK_STROBE) ? wdata : addr[7:0];
    // Bus driven only in ALE, HOLD and a write STROBE; released in IDLE, END and a read STROBE
    assign cyc.ad_oe    = (state == xmhk_pkg::XMHK_ALE) || (state == xmhk_pkg::XMHK_HOLD)
                          || ((state == xmhk_pkg::XMHK_STROBE) && write);
endmodule // xmhk_cycle
`default_nettype wire

// [verilog/xmhk_pkg.sv]
// Types shared by the external memory mask and keeper block.
// Assumes nothing of its surroundings.
package xmhk_pkg;
    typedef enum logic [2:0] {
        XMHK_IDLE,
        XMHK_ALE,
        XMHK_HOLD,
        XMHK_STROBE,
        XMHK_END
    } xmhk_state_t;
endpackage

// [verilog/xmhk_top.sv]
// External memory high-address masking and bus keeper, with AHB-Lite register slave.
// Assumes a core-side access port on hclk and pins already resolved by the bench.
// What this block does
// - Keeper enable bit 6 set turns the bus keeper on; cleared turns it off.
// - Active keeper holds the last driven value while the muxed bus is released.
// - Keeper depends only on its enable bit, not on the interface enable.
// - Interface enabled with mask zero: all eight high-address pins carry the high byte.
// - Each mask step releases one more high pin from the top; code 7 releases all.
// - Released high pins behave as plain port pins under their direction and output registers.
// - In normal mode addresses up to 0x04FF stay internal; only higher addresses start external cycles.
// - Compatibility mode shrinks internal space to 1,120 bytes, moving the external start.
// - Released pins take their level from the port output register where their direction bit is set.
// - Interface enable bit 7 takes muxed bus, high port and strobes over from the port.
`timescale 1ns/1ps
`default_nettype none
`include "xmhk_consts.svh"
module xmhk_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        acc_req,
    input  wire logic [15:0] acc_addr,
    input  wire logic        acc_write,
    input  wire logic [7:0]  acc_wdata,
    output logic             acc_done,
    output logic             acc_ext,
    output logic [7:0]       acc_rdata,
    input  wire logic [7:0]  ad_in,
    output logic [7:0]       ad_out,
    output logic [7:0]       ad_oe,
    output logic             ad_keep_en,
    output logic [7:0]       ad_keep_val,
    input  wire logic [7:0]  hi_in,
    output logic [7:0]       hi_out,
    output logic [7:0]       hi_oe,
    output logic             ale,
    output logic             rd_n,
    output logic             wr_n
);
    logic [7:0]  sfioc, next_sfioc;
    logic [7:0]  extctl, next_extctl;
    logic [7:0]  ad_port, next_ad_port;
    logic [7:0]  ad_dir, next_ad_dir;
    logic [7:0]  hi_port, next_hi_port;
    logic [7:0]  hi_dir, next_hi_dir;
    logic        wr_pend, next_wr_pend;
    logic [7:0]  wr_off, next_wr_off;
    logic [31:0] next_hrdata;
    logic [7:0]  ad_s1, ad_s2, hi_s1, hi_s2;
    logic [7:0]  last_drv, next_last_drv;
    logic [7:0]  next_ad_out, next_ad_oe, next_hi_out, next_hi_oe;
    logic        next_acc_done, next_acc_ext;
    logic [7:0]  next_acc_rdata;
    logic        pend, next_pend;
    logic        ext_en;
    logic        is_ext;
    logic [3:0]  hi_bits;
    xmhk_cyc_if  cyc();

    xmhk_cycle u_cycle (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cyc     (cyc)
    );

    function automatic logic [31:0] reg_read(input logic [7:0] off);
        if (off == `XMHK_OFF_SFIOC)
            reg_read = {24'h000000, sfioc};
        else if (off == `XMHK_OFF_EXTCTL)
            reg_read = {24'h000000, extctl};
        else if (off == `XMHK_OFF_AD_PORT)
            reg_read = {24'h000000, ad_port};
        else if (off == `XMHK_OFF_AD_DIR)
            reg_read = {24'h000000, ad_dir};
        else if (off == `XMHK_OFF_HI_PORT)
            reg_read = {24'h000000, hi_port};
        else if (off == `XMHK_OFF_HI_DIR)
            reg_read = {24'h000000, hi_dir};
        else if (off == `XMHK_OFF_STATUS)
            reg_read = {15'h0000, cyc.busy, hi_s2, ad_s2};
        else
            reg_read = 32'h00000000;
    endfunction

    assign ext_en  = extctl[`XMHK_BIT_EXT_EN];
    // Boundary moves down in compatibility mode
    assign is_ext  = extctl[`XMHK_BIT_COMPAT] ? (acc_addr > `XMHK_INT_TOP_COMPAT)
                                              : (acc_addr > `XMHK_INT_TOP_NORMAL);
    // Code 7 is not eight minus seven: it frees the whole port
    assign hi_bits = (cyc.cur_mask == 3'h7) ? 4'h0 : (`XMHK_HI_BITS - {1'b0, cyc.cur_mask});

    assign cyc.start = pend && !cyc.busy && !cyc.done;
    assign cyc.addr  = acc_addr;
    assign cyc.write = acc_write;
    assign cyc.wdata = acc_wdata;
    assign cyc.mask  = sfioc[`XMHK_MASK_MSB:`XMHK_MASK_LSB];
    assign cyc.ad_in = ad_s2;

    always_comb
    begin
        next_sfioc   = sfioc;
        next_extctl  = extctl;
        next_ad_port = ad_port;
        next_ad_dir  = ad_dir;
        next_hi_port = hi_port;
        next_hi_dir  = hi_dir;
        next_wr_pend = 1'b0;
        next_wr_off  = wr_off;
        next_hrdata  = hrdata;
        if (wr_pend)
        begin
            if (wr_off == `XMHK_OFF_SFIOC)
                next_sfioc = hwdata[7:0];
            else if (wr_off == `XMHK_OFF_EXTCTL)
                next_extctl = hwdata[7:0];
            else if (wr_off == `XMHK_OFF_AD_PORT)
                next_ad_port = hwdata[7:0];
            else if (wr_off == `XMHK_OFF_AD_DIR)
                next_ad_dir = hwdata[7:0];
            else if (wr_off == `XMHK_OFF_HI_PORT)
                next_hi_port = hwdata[7:0];
            else if (wr_off == `XMHK_OFF_HI_DIR)
                next_hi_dir = hwdata[7:0];
        end
        if (hsel && htrans[1] && hready)
        begin
            next_wr_pend = hwrite;
            next_wr_off  = haddr[7:0];
            next_hrdata  = reg_read(haddr[7:0]);
        end
    end

    always_comb
    begin
        next_pend      = pend;
        next_acc_done  = 1'b0;
        next_acc_ext   = acc_ext;
        next_acc_rdata = acc_rdata;
        if (cyc.done)
        begin
            next_pend      = 1'b0;
            next_acc_done  = 1'b1;
            next_acc_rdata = cyc.rdata;
        end
        // A request still up on the done edge belongs to the finished access
        else if (acc_req && !pend && !acc_done)
        begin
            // Internal space answers at once and never touches the pins
            next_acc_ext  = is_ext && ext_en;
            next_pend     = is_ext && ext_en;
            next_acc_done = !(is_ext && ext_en);
        end
    end

    always_comb
    begin
        next_last_drv = last_drv;
        if (ext_en)
        begin
            next_ad_out = cyc.ad_out;
            next_ad_oe  = {8{cyc.ad_oe}};
            for (int i = 0; i < 8; i++)
            begin
                if (i < int'(hi_bits))
                begin
                    next_hi_out[i] = cyc.hi_addr[i];
                    next_hi_oe[i]  = 1'b1;
                end
                else
                begin
                    next_hi_out[i] = hi_port[i];
                    next_hi_oe[i]  = hi_dir[i];
                end
            end
        end
        else
        begin
            next_ad_out = ad_port;
            next_ad_oe  = ad_dir;
            next_hi_out = hi_port;
            next_hi_oe  = hi_dir;
        end
        for (int i = 0; i < 8; i++)
        begin
            if (ad_oe[i])
                next_last_drv[i] = ad_out[i];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sfioc       <= `XMHK_RST_REG8;
            extctl      <= `XMHK_RST_REG8;
            ad_port     <= `XMHK_RST_REG8;
            ad_dir      <= `XMHK_RST_REG8;
            hi_port     <= `XMHK_RST_REG8;
            hi_dir      <= `XMHK_RST_REG8;
            wr_pend     <= 1'b0;
            wr_off      <= 8'h00;
            hrdata      <= 32'h00000000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            ad_s1       <= 8'h00;
            ad_s2       <= 8'h00;
            hi_s1       <= 8'h00;
            hi_s2       <= 8'h00;
            last_drv    <= 8'h00;
            pend        <= 1'b0;
            acc_done    <= 1'b0;
            acc_ext     <= 1'b0;
            acc_rdata   <= 8'h00;
            ad_out      <= 8'h00;
            ad_oe       <= 8'h00;
            hi_out      <= 8'h00;
            hi_oe       <= 8'h00;
            ad_keep_en  <= 1'b0;
            ad_keep_val <= 8'h00;
            ale         <= 1'b0;
            rd_n        <= 1'b1;
            wr_n        <= 1'b1;
        end
        else
        begin
            sfioc       <= next_sfioc;
            extctl      <= next_extctl;
            ad_port     <= next_ad_port;
            ad_dir      <= next_ad_dir;
            hi_port     <= next_hi_port;
            hi_dir      <= next_hi_dir;
            wr_pend     <= next_wr_pend;
            wr_off      <= next_wr_off;
            hrdata      <= next_hrdata;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            ad_s1       <= ad_in;
            ad_s2       <= ad_s1;
            hi_s1       <= hi_in;
            hi_s2       <= hi_s1;
            last_drv    <= next_last_drv;
            pend        <= next_pend;
            acc_done    <= next_acc_done;
            acc_ext     <= next_acc_ext;
            acc_rdata   <= next_acc_rdata;
            ad_out      <= next_ad_out;
            ad_oe       <= next_ad_oe;
            hi_out      <= next_hi_out;
            hi_oe       <= next_hi_oe;
            // Weak hold on its own output; not qualified by the interface enable
            ad_keep_en  <= sfioc[`XMHK_BIT_KEEPER];
            ad_keep_val <= next_last_drv;
            ale         <= ext_en && cyc.ale;
            rd_n        <= !ext_en || cyc.rd_n;
            wr_n        <= !ext_en || cyc.wr_n;
        end
    end
endmodule // xmhk_top
`default_nettype wire
